// [hw/ods_pkg.sv]
/*
  Shared constants for the octal converter serial output link.
  Assumes a 125 MHz user clock and a free-running link clock.
*/
// Overview of operation
// - All eight channels sampled at one instant.
// - Samples leave eleven sample periods later.
// - Fourteen result bits are serialised per channel.
// - Single-line mode: whole word on one pair.
// - Dual-line mode: word split over two pairs.
// - Bit clock 7x in 14-bit single-line mode (3.5x dual-line), frame clock 1x sample rate.
// - Bits centred on both bit clock edges.
// - Output resolution may drop to 12 or 10.
// - Serial configuration uses a high reset pulse.
// - Parallel configuration holds reset high permanently.
// - Reset pulse lasts at least 50 ns.
// - Wait 100 ns before asserting chip select.
// - Configuration serial clock at most 15 MHz.
// - With decimation choose the highest valid PLL state.
// - Clock single-ended by default, auto-detected.
package ods_pkg;
  localparam int CHANNELS = 8;
  localparam int SAMPLE_BITS = 14;
  localparam int LINES = 2 * CHANNELS;
  localparam int WORD_W = CHANNELS * SAMPLE_BITS;
  localparam int PIPE_LATENCY = 11;
  localparam int SLOT_CYC_SINGLE = 2;
  localparam int SLOT_CYC_DUAL = 4;
  localparam int CLK_MHZ = 125;
  localparam int CLK_PERIOD_NS = 8;
  localparam int LINK_PERIOD_NS = 6;
  localparam int RST_PULSE_NS = 50;
  localparam int RST_PULSE_CYC =
    (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_SEEN_CYC = RST_PULSE_NS / LINK_PERIOD_NS;
  localparam int CFG_WAIT_NS = 100;
  localparam int CFG_WAIT_CYC =
    (CFG_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_MAX_MHZ = 15;
  localparam int SCLK_HALF_CYC =
    (CLK_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
  localparam int CFG_WORD_BITS = 16;
  localparam int SE_DETECT_CYC = 16;
  localparam int PLL_STATES = 4;
  typedef enum logic [1:0] {ODS_RES_14, ODS_RES_12, ODS_RES_10} ods_res_t;

  // Number of output bits for a resolution code; spare code acts as 14.
  function automatic logic [3:0] res_bits(input logic [1:0] code);
    res_bits = (code == ODS_RES_12) ? 4'hc :
               (code == ODS_RES_10) ? 4'ha : 4'he;
  endfunction
endpackage

// [hw/ods_link_if.sv]
/*
  Link between the converter end and the capture end.
  Assumes the bench drives link_clock and resolves no shared pins.
*/
`timescale 1ns/100ps
interface ods_link_if;
  logic link_clock;
  logic serial_bit_clock_out;
  logic frame_clock;
  logic [ods_pkg::LINES-1:0] data_line;
  logic device_reset;
  logic config_select_n;
  logic config_sclk;
  logic config_serial_input;

  modport device (
    input link_clock, device_reset, config_select_n, config_sclk,
    input config_serial_input,
    output serial_bit_clock_out, frame_clock, data_line
  );
  modport receiver (
    input link_clock, serial_bit_clock_out, frame_clock, data_line,
    output device_reset, config_select_n, config_sclk,
    output config_serial_input
  );
endinterface

// [hw/ods_adc_end.sv]
/*
  Converter end: samples eight channels, delays them through the
  pipeline and serialises them with bit and frame clocks.
  Assumes the whole end runs on the link clock and that the sample
  and mode inputs are pins from outside this domain.
*/
`timescale 1ns/100ps
module ods_adc_end (
  // Link to the capture end.
  ods_link_if.device lnk,
  // Reset, synchronous to the link clock.
  input wire logic i_rst_n,
  // Analog sample values, taken at the frame start.
  input wire logic [ods_pkg::WORD_W-1:0] i_sample_data,
  // Mode pins.
  input wire logic [1:0] i_resolution,
  input wire logic i_dual_line,
  // Negative sampling clock pin level.
  input wire logic i_clock_neg_level,
  // Status.
  output logic o_sample_strobe,
  output logic o_clock_single_ended
);
  localparam int CH = ods_pkg::CHANNELS;
  localparam int SB = ods_pkg::SAMPLE_BITS;
  localparam int L = ods_pkg::PIPE_LATENCY;

  logic [1:0] res_s1;
  logic [1:0] res_s2;
  logic dual_s1;
  logic dual_s2;
  logic neg_s1;
  logic neg_s2;
  logic rst_s1;
  logic rst_s2;
  logic [3:0] rst_hi_cnt;
  logic pin_rst;
  logic core_rst;
  logic [1:0] res_q;
  logic dual_q;
  logic [1:0] ph;
  logic [3:0] slot;
  logic [3:0] nres;
  logic [3:0] nslots;
  logic [1:0] slot_last;
  logic frame_start;
  logic [3:0] ptr;
  logic [ods_pkg::WORD_W-1:0] pipe [L];
  logic [SB-1:0] sh_a [CH];
  logic [SB-1:0] sh_b [CH];
  logic [SB-1:0] mask;
  logic [3:0] half;
  logic bclk;
  logic frame;
  logic [4:0] low_cnt;

  // Two-flop synchronisers for the mode, negative clock and device reset pins.
  always_ff @(posedge lnk.link_clock) begin
    res_s1 <= i_resolution;
    res_s2 <= res_s1;
    dual_s1 <= i_dual_line;
    dual_s2 <= dual_s1;
    neg_s1 <= i_clock_neg_level;
    neg_s2 <= neg_s1;
    rst_s1 <= lnk.device_reset;
    rst_s2 <= rst_s1;
  end

  // The reset pin acts on its release, and only after a long enough
  // high level; a pin held high never restarts the data path.
  always_ff @(posedge lnk.link_clock) begin
    if (!i_rst_n) begin
      rst_hi_cnt <= 4'h0;
      pin_rst <= 1'b0;
    end else if (rst_s2) begin
      pin_rst <= 1'b0;
      if (rst_hi_cnt != 4'(ods_pkg::RST_SEEN_CYC)) begin
        rst_hi_cnt <= rst_hi_cnt + 4'h1;
      end
    end else begin
      pin_rst <= (rst_hi_cnt == 4'(ods_pkg::RST_SEEN_CYC));
      rst_hi_cnt <= 4'h0;
    end
  end

  assign core_rst = !i_rst_n || pin_rst;

  // Frame geometry for the modes latched at the last frame boundary.
  always_comb begin
    nres = ods_pkg::res_bits(res_q);
    half = nres >> 1;
    nslots = dual_q ? half : nres;
    slot_last = dual_q ? 2'(ods_pkg::SLOT_CYC_DUAL - 1) :
                         2'(ods_pkg::SLOT_CYC_SINGLE - 1);
    frame_start = (ph == 2'h0) && (slot == 4'h0);
    mask = ~(SB'(14'h3fff) >> nres);
  end

  // Slot and phase counters; modes change only between frames.
  always_ff @(posedge lnk.link_clock) begin
    if (core_rst) begin
      ph <= 2'h0;
      slot <= 4'h0;
      res_q <= ods_pkg::ODS_RES_14;
      dual_q <= 1'b0;
    end else if (ph == slot_last) begin
      ph <= 2'h0;
      if (slot == nslots - 4'h1) begin
        slot <= 4'h0;
        res_q <= res_s2;
        dual_q <= dual_s2;
      end else begin
        slot <= slot + 4'h1;
      end
    end else begin
      ph <= ph + 2'h1;
    end
  end

  // Delay line: each frame start stores all channels at once and
  // releases the set stored eleven frames earlier.
  always_ff @(posedge lnk.link_clock) begin
    if (core_rst) begin
      ptr <= 4'h0;
      for (int i = 0; i < L; i++) begin
        pipe[i] <= '0;
      end
    end else if (frame_start) begin
      pipe[ptr] <= i_sample_data;
      ptr <= (ptr == 4'(L - 1)) ? 4'h0 : ptr + 4'h1;
    end
  end

  // Shift registers that turn each channel word into serial bits.
  always_ff @(posedge lnk.link_clock) begin
    if (core_rst) begin
      for (int c = 0; c < CH; c++) begin
        sh_a[c] <= '0;
        sh_b[c] <= '0;
      end
    end else if (frame_start) begin
      for (int c = 0; c < CH; c++) begin
        if (dual_q) begin
          sh_a[c] <= pipe[ptr][c*SB +: SB] & mask & ~(mask >> half);
          sh_b[c] <= (pipe[ptr][c*SB +: SB] & mask) << half;
        end else begin
          sh_a[c] <= pipe[ptr][c*SB +: SB] & mask;
          sh_b[c] <= '0;
        end
      end
    end else if (ph == 2'h0) begin
      for (int c = 0; c < CH; c++) begin
        sh_a[c] <= sh_a[c] << 1;
        sh_b[c] <= sh_b[c] << 1;
      end
    end
  end

  // The bit clock toggles in the middle of each bit so that both of
  // its edges fall inside the data eye.
  always_ff @(posedge lnk.link_clock) begin
    if (core_rst) begin
      bclk <= 1'b0;
    end else if (ph == 2'(slot_last >> 1) + 2'h1) begin
      bclk <= !bclk;
    end
  end

  // Frame clock is high for the first half of the slots of a word, rounded down.
  always_ff @(posedge lnk.link_clock) begin
    if (core_rst) begin
      frame <= 1'b0;
    end else if (ph == 2'h0) begin
      frame <= (slot < (nslots >> 1)) || (slot == 4'h0);
    end
  end

  // Strobe marks the cycle after a sample set was taken.
  always_ff @(posedge lnk.link_clock) begin
    if (core_rst) begin
      o_sample_strobe <= 1'b0;
    end else begin
      o_sample_strobe <= frame_start;
    end
  end

  // A negative clock pin that stays low is taken as single-ended.
  always_ff @(posedge lnk.link_clock) begin
    if (!i_rst_n) begin
      low_cnt <= 5'h00;
      o_clock_single_ended <= 1'b1;
    end else if (neg_s2) begin
      low_cnt <= 5'h00;
      o_clock_single_ended <= 1'b0;
    end else if (low_cnt == 5'(ods_pkg::SE_DETECT_CYC)) begin
      o_clock_single_ended <= 1'b1;
    end else begin
      low_cnt <= low_cnt + 5'h01;
    end
  end

  // Line 2c carries the first half or whole word, line 2c+1 the rest.
  always_comb begin
    for (int c = 0; c < CH; c++) begin
      lnk.data_line[2*c] = sh_a[c][SB-1];
      lnk.data_line[2*c+1] = sh_b[c][SB-1];
    end
  end

  assign lnk.serial_bit_clock_out = bclk;
  assign lnk.frame_clock = frame;
endmodule // ods_adc_end

// [hw/ods_capture_end.sv]
/*
  Capture end: drives reset and the configuration port, recovers
  words from the serial lines and hands them to the user clock.
  Assumes link_clock is the same clock that times the converter end.
*/
`timescale 1ns/100ps
module ods_capture_end (
  // Link to the converter end.
  ods_link_if.receiver lnk,
  // User clock and synchronous reset.
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Mode settings, which must match the converter end.
  input wire logic [1:0] i_resolution,
  input wire logic i_dual_line,
  input wire logic i_parallel_mode,
  // Configuration request.
  input wire logic i_config_start,
  input wire logic [ods_pkg::CFG_WORD_BITS-1:0] i_config_word,
  input wire logic i_decimation_on,
  input wire logic [ods_pkg::PLL_STATES-1:0] i_pll_state_ok,
  // Word output.
  output logic o_word_valid,
  input wire logic i_word_ready,
  output logic [ods_pkg::WORD_W-1:0] o_word_data,
  // Status.
  output logic o_overrun,
  output logic o_config_ready,
  output logic o_config_busy,
  output logic [1:0] o_pll_state
);
  localparam int CH = ods_pkg::CHANNELS;
  localparam int SB = ods_pkg::SAMPLE_BITS;
  typedef enum logic [1:0] {SEQ_PULSE, SEQ_WAIT, SEQ_IDLE, SEQ_SHIFT}
    ods_seq_t;

  ods_seq_t seq;
  logic [4:0] cnt;
  logic [3:0] bitc;
  logic [ods_pkg::CFG_WORD_BITS-1:0] cfg_sh;
  logic sclk;
  logic csn;
  logic dev_rst;
  logic lr1, lr2, lrst;
  logic [1:0] res1, res2;
  logic dual1, dual2;
  logic bclk_q, frame_q, edge_seen, start;
  logic [1:0] res_l;
  logic dual_l;
  logic [3:0] slotc, nres, nslots, next_slotc;
  logic [SB-1:0] acc_a [CH];
  logic [SB-1:0] acc_b [CH];
  logic [ods_pkg::WORD_W-1:0] next_word, pend;
  logic pend_v, ovr_tgl, full, empty;
  logic [1:0] wbin, rbin, wg1, wg2, rg1, rg2, wgray, rgray;
  logic [ods_pkg::WORD_W-1:0] mem [2];
  logic ov1, ov2, ov3;

  // Reset pulse, settle wait and serial configuration shifter.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      seq <= SEQ_PULSE;
      cnt <= 5'h00;
      bitc <= 4'h0;
      cfg_sh <= '0;
      sclk <= 1'b0;
      csn <= 1'b1;
    end else begin
      case (seq)
        SEQ_PULSE: begin
          cnt <= cnt + 5'h01;
          if (cnt == 5'(ods_pkg::RST_PULSE_CYC - 1)) begin
            cnt <= 5'h00;
            seq <= SEQ_WAIT;
          end
        end
        SEQ_WAIT: begin
          cnt <= cnt + 5'h01;
          if (cnt == 5'(ods_pkg::CFG_WAIT_CYC - 1)) begin
            cnt <= 5'h00;
            seq <= SEQ_IDLE;
          end
        end
        SEQ_IDLE: begin
          if (i_config_start && !i_parallel_mode) begin
            cfg_sh <= i_config_word;
            csn <= 1'b0;
            bitc <= 4'h0;
            seq <= SEQ_SHIFT;
          end
        end
        SEQ_SHIFT: begin
          cnt <= cnt + 5'h01;
          if (cnt == 5'(ods_pkg::SCLK_HALF_CYC - 1)) begin
            cnt <= 5'h00;
            sclk <= !sclk;
            if (sclk && bitc == 4'hf) begin
              csn <= 1'b1;
              seq <= SEQ_IDLE;
            end else if (sclk) begin
              bitc <= bitc + 4'h1;
              cfg_sh <= cfg_sh << 1;
            end
          end
        end
        default: seq <= SEQ_IDLE;
      endcase
    end
  end

  // High pulse after reset, or held high for pin configuration.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      dev_rst <= 1'b1;
    end else begin
      dev_rst <= i_parallel_mode || (seq == SEQ_PULSE);
    end
  end

  // Pick a PLL state: highest valid with decimation, else lowest.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_pll_state <= 2'h0;
    end else begin
      for (int i = 0; i < ods_pkg::PLL_STATES; i++) begin
        if (i_pll_state_ok[i] && i_decimation_on) o_pll_state <= 2'(i);
      end
      for (int i = ods_pkg::PLL_STATES - 1; i >= 0; i--) begin
        if (i_pll_state_ok[i] && !i_decimation_on) o_pll_state <= 2'(i);
      end
    end
  end

  assign lnk.device_reset = dev_rst;
  assign lnk.config_select_n = csn;
  assign lnk.config_sclk = sclk;
  assign lnk.config_serial_input = cfg_sh[ods_pkg::CFG_WORD_BITS-1];
  assign o_config_ready = (seq == SEQ_IDLE) && !i_parallel_mode;
  assign o_config_busy = (seq == SEQ_SHIFT);

  // Reset and mode settings cross into the link domain.
  always_ff @(posedge lnk.link_clock) begin
    lr1 <= i_rst_n;
    lr2 <= lr1;
    res1 <= i_resolution;
    res2 <= res1;
    dual1 <= i_dual_line;
    dual2 <= dual1;
    rg1 <= rgray;
    rg2 <= rg1;
  end
  assign lrst = !lr2;

  // Bits are taken at every change of the bit clock, either way, and
  // a rising frame clock marks the first bit of a word.
  always_comb begin
    edge_seen = lnk.serial_bit_clock_out != bclk_q;
    start = edge_seen && lnk.frame_clock && !frame_q;
    nres = ods_pkg::res_bits(start ? res2 : res_l);
    nslots = (start ? dual2 : dual_l) ? (nres >> 1) : nres;
    next_slotc = start ? 4'h1 : slotc + 4'h1;
    for (int c = 0; c < CH; c++) begin
      if (start ? dual2 : dual_l) begin
        next_word[c*SB +: SB] = (((({acc_a[c][SB-2:0], lnk.data_line[2*c]})
          << (nres >> 1)) | {acc_b[c][SB-2:0], lnk.data_line[2*c+1]})
          << (4'(SB) - nres));
      end else begin
        next_word[c*SB +: SB] = {acc_a[c][SB-2:0], lnk.data_line[2*c]}
          << (4'(SB) - nres);
      end
    end
  end

  // Word assembly, hold stage and overrun detection.
  always_ff @(posedge lnk.link_clock) begin
    if (lrst) begin
      bclk_q <= 1'b0;
      frame_q <= 1'b1;
      slotc <= 4'h0;
      res_l <= ods_pkg::ODS_RES_14;
      dual_l <= 1'b0;
      pend_v <= 1'b0;
      pend <= '0;
      ovr_tgl <= 1'b0;
      for (int c = 0; c < CH; c++) begin
        acc_a[c] <= '0;
        acc_b[c] <= '0;
      end
    end else begin
      bclk_q <= lnk.serial_bit_clock_out;
      if (pend_v && !full) pend_v <= 1'b0;
      if (edge_seen) frame_q <= lnk.frame_clock;
      if (start) begin
        res_l <= res2;
        dual_l <= dual2;
      end
      if (start || (edge_seen && slotc != 4'h0)) begin
        slotc <= (next_slotc == nslots) ? 4'h0 : next_slotc;
        for (int c = 0; c < CH; c++) begin
          acc_a[c] <= start ? SB'(lnk.data_line[2*c])
                            : {acc_a[c][SB-2:0], lnk.data_line[2*c]};
          acc_b[c] <= start ? SB'(lnk.data_line[2*c+1])
                            : {acc_b[c][SB-2:0], lnk.data_line[2*c+1]};
        end
        if (next_slotc == nslots) begin
          if (pend_v && full) begin
            ovr_tgl <= !ovr_tgl;
          end else begin
            pend <= next_word;
            pend_v <= 1'b1;
          end
        end
      end
    end
  end

  // Two-entry buffer with gray pointers between the clocks.
  always_comb begin
    wgray = wbin ^ (wbin >> 1);
    rgray = rbin ^ (rbin >> 1);
    full = (wgray == ~rg2);
    empty = (rgray == wg2);
  end
  always_ff @(posedge lnk.link_clock) begin
    if (lrst) begin
      wbin <= 2'h0;
    end else if (pend_v && !full) begin
      mem[wbin[0]] <= pend;
      wbin <= wbin + 2'h1;
    end
  end
  always_ff @(posedge i_clock) begin
    wg1 <= wgray;
    wg2 <= wg1;
    ov1 <= ovr_tgl;
    ov2 <= ov1;
    ov3 <= ov2;
    if (!i_rst_n) begin
      rbin <= 2'h0;
      o_overrun <= 1'b0;
    end else begin
      o_overrun <= ov2 ^ ov3;
      if (!empty && i_word_ready) rbin <= rbin + 2'h1;
    end
  end
  assign o_word_valid = !empty;
  assign o_word_data = mem[rbin[0]];
endmodule // ods_capture_end

// [tb/ods_link_chk.sv]
/*
  Checker for the link between the converter and capture ends.
  Assumes it sees the link signals plus the user clock and reset.
*/
`timescale 1ns/100ps
module ods_link_chk (
  // Link signals.
  input wire logic link_clock,
  input wire logic serial_bit_clock_out,
  input wire logic frame_clock,
  input wire logic [ods_pkg::LINES-1:0] data_line,
  input wire logic device_reset,
  input wire logic config_select_n,
  input wire logic config_sclk,
  input wire logic config_serial_input,
  // User clock and reset.
  input wire logic i_clock,
  input wire logic i_rst_n
);
  logic [7:0] fr_cnt;
  logic [7:0] hi_cnt = 8'h0;
  logic [7:0] lo_cnt = 8'h0;

  // Link cycles since the last frame start, zero until framing resumes.
  always_ff @(posedge link_clock) begin
    if (!i_rst_n || device_reset) begin
      fr_cnt <= 8'h0;
    end else if ($rose(frame_clock)) begin
      fr_cnt <= 8'h1;
    end else if (fr_cnt != 8'h0 && fr_cnt != 8'hff) begin
      fr_cnt <= fr_cnt + 8'h1;
    end
  end

  // Length of the present high run of the device reset.
  always @(posedge i_clock) begin
    hi_cnt <= (device_reset !== 1'b1) ? 8'h0 :
      hi_cnt + {7'h0, hi_cnt != 8'hff};
  end

  // Length of the present low run of the device reset.
  always @(posedge i_clock) begin
    lo_cnt <= (device_reset !== 1'b0) ? 8'h0 :
      lo_cnt + {7'h0, lo_cnt != 8'hff};
  end

  // Each serial clock phase spans at least five user cycles.
  sequence s_sclk_high;
    config_sclk [*5];
  endsequence
  sequence s_sclk_low;
    !config_sclk [*5];
  endsequence

  // Relations on the data side of the link.
  a_lines_off_edge: assert property (@(posedge link_clock)
    disable iff (!i_rst_n) fr_cnt != 8'h0 && $changed(data_line)
    |-> $stable(serial_bit_clock_out)) else $error("data moved with clock");
  a_bclk_half_bit: assert property (@(posedge link_clock)
    disable iff (!i_rst_n) fr_cnt != 8'h0 && $changed(serial_bit_clock_out)
    |=> $stable(serial_bit_clock_out)) else $error("bit clock too fast");
  a_frame_high_two: assert property (@(posedge link_clock)
    disable iff (!i_rst_n) fr_cnt != 8'h0 && $rose(frame_clock)
    |=> frame_clock) else $error("frame clock pulse too short");
  a_frame_period: assert property (@(posedge link_clock)
    disable iff (!i_rst_n) $rose(frame_clock) && fr_cnt != 8'h0
    |-> fr_cnt inside {8'h14, 8'h18, 8'h1c}) else $error("bad frame length");
  // Relations on the reset and configuration side.
  a_reset_pulse_len: assert property (@(posedge i_clock)
    disable iff (!i_rst_n) $fell(device_reset)
    |-> hi_cnt >= ods_pkg::RST_PULSE_CYC) else $error("reset pulse short");
  a_config_wait_long: assert property (@(posedge i_clock)
    disable iff (!i_rst_n) $fell(config_select_n)
    |-> !device_reset && lo_cnt >= ods_pkg::CFG_WAIT_CYC)
    else $error("select too soon after reset");
  a_reset_no_select: assert property (@(posedge i_clock)
    disable iff (!i_rst_n) device_reset |-> config_select_n)
    else $error("select during reset");
  a_sclk_high_len: assert property (@(posedge i_clock)
    disable iff (!i_rst_n) $rose(config_sclk) |-> s_sclk_high)
    else $error("serial clock high too short");
  a_sclk_low_len: assert property (@(posedge i_clock)
    disable iff (!i_rst_n) $fell(config_sclk) |-> s_sclk_low)
    else $error("serial clock low too short");
endmodule // ods_link_chk

// [tb/tb_octal_adc_serial_data_output.sv]
/*
  Bench joining the converter and capture ends through the link.
  Assumes both ends share the link clock made here at 6 ns.
*/
`timescale 1ns/100ps
module tb_octal_adc_serial_data_output;
  logic i_clock = 1'b0;
  logic rst_n = 1'b0;
  logic [111:0] smp = '0;
  logic [1:0] res = 2'h0;
  logic dual = 1'b0;
  logic neg = 1'b0;
  logic par = 1'b0;
  logic go = 1'b0;
  logic dec = 1'b0;
  logic rdy = 1'b1;
  logic [15:0] cw = 16'h0;
  logic [3:0] pok = 4'h1;
  logic stb, se, wv, ovr, crdy, cbsy;
  logic [111:0] wd;
  logic [1:0] pll;
  int mismatches = 0;
  int tests_run = 0;
  ods_link_if lf();

  // Clocks whose rising edges never coincide.
  always #4 i_clock = ~i_clock;
  initial lf.link_clock = 1'b0;
  always #3 lf.link_clock = ~lf.link_clock;

  ods_adc_end ods_adc_end_i (.lnk(lf), .i_rst_n(rst_n), .i_sample_data(smp),
    .i_resolution(res), .i_dual_line(dual), .i_clock_neg_level(neg),
    .o_sample_strobe(stb), .o_clock_single_ended(se));
  ods_capture_end ods_capture_end_i (.lnk(lf), .i_clock(i_clock),
    .i_rst_n(rst_n), .i_resolution(res), .i_dual_line(dual),
    .i_parallel_mode(par), .i_config_start(go), .i_config_word(cw),
    .i_decimation_on(dec), .i_pll_state_ok(pok), .o_word_valid(wv),
    .i_word_ready(rdy), .o_word_data(wd), .o_overrun(ovr),
    .o_config_ready(crdy), .o_config_busy(cbsy), .o_pll_state(pll));
  ods_link_chk ods_link_chk_i (.link_clock(lf.link_clock),
    .serial_bit_clock_out(lf.serial_bit_clock_out),
    .frame_clock(lf.frame_clock), .data_line(lf.data_line),
    .device_reset(lf.device_reset), .config_select_n(lf.config_select_n),
    .config_sclk(lf.config_sclk),
    .config_serial_input(lf.config_serial_input), .i_clock(i_clock),
    .i_rst_n(rst_n));

  // Compares a value, counts it and reports a difference.
  task automatic chk(input string nm, input logic [111:0] e,
    input logic [111:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Waits for settled link or user cycles.
  task automatic lk(input int n);
    repeat (n) @(negedge lf.link_clock);
  endtask
  task automatic uk(input int n);
    repeat (n) @(negedge i_clock);
  endtask

  // Eight channel words from one base, low bits dropped as the mode asks.
  function automatic logic [111:0] pat(input logic [13:0] b, input int d);
    logic [13:0] m;
    m = 14'h3fff << d;
    for (int c = 0; c < 8; c++) begin
      pat[14*c +: 14] = (b ^ (14'h0101 * 14'(c))) & m;
    end
  endfunction

  // Counts link cycles and bit clock edges up to the next frame start.
  task automatic rise_wait(output int n, output int e);
    logic pf;
    logic pb;
    logic rose;
    n = 0;
    e = 0;
    pf = lf.frame_clock;
    pb = lf.serial_bit_clock_out;
    do begin
      lk(1);
      n++;
      e += int'(lf.serial_bit_clock_out !== pb);
      pb = lf.serial_bit_clock_out;
      rose = (lf.frame_clock === 1'b1) && (pf === 1'b0);
      pf = lf.frame_clock;
    end while (!rose && n < 100);
  endtask

  // Takes the next word from the output.
  task automatic get_word(output logic [111:0] w);
    for (int n = 0; n < 200 && wv !== 1'b1; n++) uk(1);
    w = wd;
    uk(1);
  endtask

  // Runs one resolution and line mode and checks framing and a word.
  task automatic s_mode(input logic [1:0] r, input logic d, input int b);
    int n;
    int e;
    logic [111:0] w;
    @(posedge lf.link_clock);
    res <= r;
    dual <= d;
    smp <= pat(14'h1234, 0);
    lk(480);
    rise_wait(n, e);
    rise_wait(n, e);
    chk("frame length", 112'(2 * b), 112'(n));
    chk("bit clock edges", 112'(d ? b / 2 : b), 112'(e));
    get_word(w);
    chk("word", pat(14'h1234, 14 - b), w);
  endtask

  // Changes every channel at once and counts frames to the change.
  task automatic s_latency;
    int n;
    int e;
    logic [15:0] l10;
    @(posedge lf.link_clock);
    smp <= pat(14'h2c6b, 0);
    lk(2); // Skips a strobe for a set taken before the change.
    for (n = 0; n < 100 && stb !== 1'b1; n++) lk(1);
    repeat (10) rise_wait(n, e);
    l10 = lf.data_line & 16'h5555;
    rise_wait(n, e);
    chk("lines before", 112'h0, {96'h0, l10});
    chk("lines after", 112'h5555, {96'h0, lf.data_line & 16'h5555});
  endtask

  // Stalls the output until a word is lost, then drains the buffer.
  task automatic s_stall;
    int c;
    logic seen;
    seen = 1'b0;
    lk(40); // Lets the last word of the old samples leave first.
    @(posedge i_clock);
    rdy <= 1'b0;
    for (int n = 0; n < 200; n++) begin
      uk(1);
      seen |= (ovr === 1'b1);
    end
    chk("overrun", 112'h1, {111'h0, seen});
    chk("valid held", 112'h1, {111'h0, wv});
    @(posedge i_clock);
    rdy <= 1'b1;
    uk(1);
    for (c = 0; c < 4 && wv === 1'b1; c++) begin
      chk("drained word", pat(14'h2c6b, 0), wd);
      uk(1);
    end
    chk("drained count", 112'h1, {111'h0, c >= 2});
  endtask

  // Sends a configuration word and reads it back off the serial port.
  task automatic s_config;
    int p;
    int mp;
    int nb;
    logic [15:0] got;
    logic ps;
    for (int n = 0; n < 100 && crdy !== 1'b1; n++) uk(1);
    @(posedge i_clock);
    cw <= 16'hb4e1;
    go <= 1'b1;
    @(posedge i_clock);
    go <= 1'b0;
    uk(1);
    chk("busy", 112'h1, {111'h0, cbsy});
    ps = 1'b0;
    mp = 999;
    nb = 0;
    p = 0;
    got = 16'h0;
    for (int n = 0; n < 400; n++) begin
      uk(1);
      p++;
      if (lf.config_sclk === 1'b1 && ps === 1'b0) begin
        got = {got[14:0], lf.config_serial_input};
        nb++;
        mp = (nb > 1 && p < mp) ? p : mp;
        p = 0;
      end
      ps = lf.config_sclk;
    end
    chk("config word", 112'hb4e1, {96'h0, got});
    chk("config bits", 112'h10, 112'(nb));
    chk("sclk period", 112'h1, {111'h0, mp >= 9});
  endtask

  // Steps the PLL choice; entries hold decimation, mask and result.
  task automatic s_pll;
    logic [6:0] t [3] = '{7'h5a, 7'h19, 7'h6f};
    for (int i = 0; i < 3; i++) begin
      @(posedge i_clock);
      dec <= t[i][6];
      pok <= t[i][5:2];
      uk(4);
      chk("pll state", 112'(t[i][1:0]), 112'(pll));
    end
  endtask

  // Drives the negative clock pin high and low again.
  task automatic s_clk_detect;
    chk("single ended at start", 112'h1, {111'h0, se});
    @(posedge lf.link_clock);
    neg <= 1'b1;
    lk(6);
    chk("differential", 112'h0, {111'h0, se});
    @(posedge lf.link_clock);
    neg <= 1'b0;
    lk(10);
    chk("still differential", 112'h0, {111'h0, se});
    lk(14);
    chk("single ended again", 112'h1, {111'h0, se});
  endtask

  // Parallel mode holds the device reset and refuses configuration.
  task automatic s_parallel;
    @(posedge i_clock);
    par <= 1'b1;
    uk(20);
    chk("reset held", 112'h1, {111'h0, lf.device_reset});
    chk("config refused", 112'h0, {111'h0, crdy});
    @(posedge i_clock);
    go <= 1'b1;
    @(posedge i_clock);
    go <= 1'b0;
    uk(30);
    chk("select idle", 112'h1, {111'h0, lf.config_select_n});
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_sim;
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    repeat (4) @(posedge i_clock);
    rst_n <= 1'b1;
    uk(2);
    chk("reset pulse", 112'h1, {111'h0, lf.device_reset});
    s_clk_detect();
    s_pll();
    s_config();
    for (int i = 5; i >= 0; i--) begin
      s_mode(2'(i % 3), i / 3 == 1, 14 - 2 * (i % 3));
    end
    s_latency();
    s_stall();
    s_parallel();
    end_sim();
  end

  // Cuts a hang short well after the expected run time.
  initial begin
    #300000;
    mismatches++;
    $display("MISMATCH watchdog expected finish seen timeout");
    end_sim();
  end
endmodule // tb_octal_adc_serial_data_output
